// ### hw/scl_defines.svh
/*
 * Named constants of the shared-image serial configuration loader: timing,
 * flash read command layout and pin slot positions.
 * Assumes a 40 MHz system clock; included by bare name.
 */
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// ***************************************************************
// timing
// ***************************************************************
`define SCL_CLK_PERIOD_NS      25
`define SCL_CFGCLK_MAX_NS      50
`define SCL_CFGCLK_NOM_PS      38460
// longest period rounds down; nominal period is not reachable from 40 MHz
`define SCL_HALF_CYC           ((`SCL_CFGCLK_MAX_NS / `SCL_CLK_PERIOD_NS) / 2)
`define SCL_RESTART_NS         40000
`define SCL_RESTART_CYC        (`SCL_RESTART_NS / `SCL_CLK_PERIOD_NS)
`define SCL_SYNC_LAG           2

// ***************************************************************
// flash read sequence and image
// ***************************************************************
`define SCL_READ_CMD           8'h03
`define SCL_START_ADDR         24'h000000
`define SCL_CMD_BITS           32
`define SCL_RUN_BITS           3
`define SCL_IMAGE_BITS         1223980

// ***************************************************************
// pin slots in the synchroniser vector
// ***************************************************************
`define SCL_NPINS              6
`define SCL_PIN_DATA           0
`define SCL_PIN_DONE           1
`define SCL_PIN_STATUS         2
`define SCL_PIN_CHAIN          3
`define SCL_PIN_RECONF         4
`define SCL_PIN_AUTO           5

`endif

// ### hw/scl_pkg.sv
/*
 * Types of the serial configuration loader: states and carriers.
 * Assumes nothing beyond the defines header.
 */
package scl_pkg;

	// ***************************************************************
	// state machines
	// ***************************************************************
	typedef enum logic [2:0] {S_RESET, S_WAIT_STATUS, S_FETCH, S_DONE, S_ERROR} scl_state_t;
	typedef enum logic [1:0] {D_TYPE, D_LIT, D_RUN} scl_dec_t;

	// ***************************************************************
	// carriers
	// ***************************************************************
	// decoded image bits toward the configuration core
	typedef struct packed {
		logic       valid;
		logic       bit_val;
		logic [3:0] reps;
	} scl_cfg_t;

	// raw pin levels, slot order matches the defines header
	typedef struct packed {
		logic auto_restart;
		logic reconfig_req_n;
		logic chain_enable_in;
		logic config_status;
		logic load_complete;
		logic serial_config_data;
	} scl_pins_t;

endpackage

// ### hw/scl_clkgen.sv
/*
 * Divider that makes the configuration clock from the system clock and
 * marks its rising and falling edges with one-cycle flags.
 * Assumes run is a registered level from the same clock domain.
 */
`timescale 1ns/100ps
`include "scl_defines.svh"

module scl_clkgen
	import scl_pkg::*;
#(
	parameter int HALF_CYC = `SCL_HALF_CYC
)(
	// system
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// control
	input  wire logic run,
	// generated clock
	output logic      sclk,
	output logic      rise_p,
	output logic      fall_p
);
	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_sclk;
	logic          next_rise_p;
	logic          next_fall_p;

	// ***************************************************************
	// divider: stopped low so the flash sees no stray edge when idle
	// ***************************************************************
	always_comb
	begin
		next_cnt    = cnt;
		next_sclk   = sclk;
		next_rise_p = 1'b0;
		next_fall_p = 1'b0;
		if (!run)
		begin
			next_cnt  = '0;
			next_sclk = 1'b0;
			next_fall_p = sclk;
		end
		else if (cnt == CW'(HALF_CYC - 1))
		begin
			next_cnt    = '0;
			next_sclk   = ~sclk;
			next_rise_p = ~sclk;
			next_fall_p = sclk;
		end
		else
			next_cnt = cnt + CW'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt    <= '0;
			sclk   <= 1'b0;
			rise_p <= 1'b0;
			fall_p <= 1'b0;
		end
		else if (ce)
		begin
			cnt    <= next_cnt;
			sclk   <= next_sclk;
			rise_p <= next_rise_p;
			fall_p <= next_fall_p;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	a_clock_half: assert property (@(posedge clk) disable iff (rst) // [RULE10] [RULE12]
		(ce && sclk && HALF_CYC == 1) |=> !sclk)
		else $error("configuration clock high longer than half the period");

endmodule // scl_clkgen

// ### hw/scl_loader.sv
/*
 * Chain master of a shared-image serial configuration chain: fetches one
 * image from serial flash on its own clock, decodes it, and steers the
 * shared open-drain done and status lines.
 * Assumes board pull-ups on open-drain lines and a 40 MHz clk.
 */
// Overview of operation
// RULE1 - master runs self-fetch mode, reading flash and driving shared data and clock.
// RULE2 - every slave is strapped to host-fed mode, scheme-select pattern 01.
// RULE3 - flash holds one image; master and slaves load it together in one cycle.
// RULE4 - chain enable input of every device is tied low for concurrent loading.
// RULE5 - chain enable output plays no sequencing part; ordinary output.
// RULE6 - slaves sample the same data line on the master's configuration clock.
// RULE7 - buffers toward slaves keep data-to-clock timing and leave flash path alone.
// RULE8 - compressed and uncompressed images accepted; compressed decoded on the fly.
// RULE9 - configuration clock comes from the internal divider and times all flash transfers.
// RULE10 - configuration clock period never above 50 ns, at least 20 MHz.
// RULE11 - exactly one image bit moves per configuration clock cycle.
// RULE12 - nominal configuration clock period is 38.46 ns; the divider gives 50 ns.
// RULE13 - chain enable high: master releases flash pins and makes no accesses.
// RULE14 - reconfigure request low keeps the device in reset, no activity.
// RULE15 - programmer releases chain enable and reconfigure request when done.
// RULE16 - device releases load-complete line after receiving all its data.
// RULE17 - on error pull status low; auto restart within 40 us.
// RULE18 - reconfigure request rising leaves reset and releases status line.
// RULE19 - fetch: select low, read command with address zero, stream until done.
`timescale 1ns/100ps
`include "scl_defines.svh"

module scl_loader
	import scl_pkg::*;
#(
	parameter int IMAGE_BITS = `SCL_IMAGE_BITS
)(
	// system
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      ce,
	// pins from outside, synchronised here
	input  wire scl_pins_t pins_in,
	// flash interface, released while not fetching
	output logic           flash_select_n,
	output logic           flash_select_n_oe,
	output logic           flash_command_out,
	output logic           flash_command_out_oe,
	output logic           config_clock,
	output logic           config_clock_oe,
	// shared open-drain lines, driven low while oe is high
	output logic           load_complete_out,
	output logic           load_complete_oe,
	output logic           config_status_out,
	output logic           config_status_oe,
	// user side
	output logic           chain_enable_out,
	output scl_cfg_t       cfg_out
);
	localparam int CNT_W = $clog2(IMAGE_BITS + 16);

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic [`SCL_NPINS-1:0] sync1;
	logic [`SCL_NPINS-1:0] sync2;

	// first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < `SCL_NPINS; gi++)
		begin : g_sync
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end
				else if (ce)
				begin
					sync1[gi] <= pins_in[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	logic data_s;
	logic done_s;
	logic status_s;
	logic chain_s;
	logic reconf_s;
	logic auto_s;
	assign data_s   = sync2[`SCL_PIN_DATA];
	assign done_s   = sync2[`SCL_PIN_DONE];
	assign status_s = sync2[`SCL_PIN_STATUS];
	assign chain_s  = sync2[`SCL_PIN_CHAIN];
	assign reconf_s = sync2[`SCL_PIN_RECONF];
	assign auto_s   = sync2[`SCL_PIN_AUTO];

	// ***************************************************************
	// configuration clock divider
	// ***************************************************************
	logic run;
	logic rise_p;
	logic fall_p;

	// the same clock times flash reads and slave sampling
	scl_clkgen #(.HALF_CYC(`SCL_HALF_CYC)) u_clkgen ( // [RULE9] [RULE6]
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.run    (run),
		.sclk   (config_clock),
		.rise_p (rise_p),
		.fall_p (fall_p)
	);

	// ***************************************************************
	// sequencer state
	// ***************************************************************
	scl_state_t                  state;
	scl_state_t                  next_state;
	scl_dec_t                    dec;
	scl_dec_t                    next_dec;
	logic [`SCL_CMD_BITS-1:0]    cmd_sr;
	logic [`SCL_CMD_BITS-1:0]    next_cmd_sr;
	logic [5:0]                  samp_cnt;
	logic [5:0]                  next_samp_cnt;
	logic [`SCL_SYNC_LAG-1:0]    rise_dly;
	logic [`SCL_SYNC_LAG-1:0]    next_rise_dly;
	logic                        hdr_seen;
	logic                        next_hdr_seen;
	logic                        comp;
	logic                        next_comp;
	logic [`SCL_RUN_BITS-1:0]    run_acc;
	logic [`SCL_RUN_BITS-1:0]    next_run_acc;
	logic [1:0]                  run_got;
	logic [1:0]                  next_run_got;
	logic [CNT_W-1:0]            out_cnt;
	logic [CNT_W-1:0]            next_out_cnt;
	logic [10:0]                 err_cnt;
	logic [10:0]                 next_err_cnt;
	logic                        done_prev;
	scl_cfg_t                    next_cfg;
	logic                        strobe;
	logic                        emit;
	logic                        emit_bit;
	logic [3:0]                  emit_reps;

	// data sampling trails the clock rise by the synchroniser depth
	assign strobe = rise_dly[`SCL_SYNC_LAG-1];

	// ***************************************************************
	// image decoder: header bit picks compressed or plain stream
	// ***************************************************************
	// compressed: 0,b is a literal bit; 1,nnn is a run of nnn+1 zeros
	always_comb
	begin
		next_dec      = dec;
		next_hdr_seen = hdr_seen;
		next_comp     = comp;
		next_run_acc  = run_acc;
		next_run_got  = run_got;
		emit          = 1'b0;
		emit_bit      = 1'b0;
		emit_reps     = 4'h1;
		if (state == S_FETCH && strobe && samp_cnt == 6'(`SCL_CMD_BITS))
		begin
			if (!hdr_seen)
			begin
				next_hdr_seen = 1'b1;
				next_comp     = data_s;
			end
			else if (!comp)
			begin
				emit     = 1'b1; // [RULE11]
				emit_bit = data_s;
			end
			else
			begin
				unique case (dec) // [RULE8]
					D_TYPE:
					begin
						next_dec     = data_s ? D_RUN : D_LIT;
						next_run_acc = '0;
						next_run_got = '0;
					end
					D_LIT:
					begin
						emit     = 1'b1;
						emit_bit = data_s;
						next_dec = D_TYPE;
					end
					D_RUN:
					begin
						next_run_acc = {run_acc[`SCL_RUN_BITS-2:0], data_s};
						next_run_got = run_got + 2'h1;
						if (run_got == 2'(`SCL_RUN_BITS - 1))
						begin
							emit      = 1'b1;
							emit_reps = {1'b0, run_acc[`SCL_RUN_BITS-2:0], data_s} + 4'h1;
							next_dec  = D_TYPE;
						end
					end
					default: next_dec = D_TYPE;
				endcase
			end
		end
		next_cfg.valid   = emit;
		next_cfg.bit_val = emit_bit;
		next_cfg.reps    = emit_reps;
	end

	// ***************************************************************
	// sequencer: reset, wait for status, fetch, done, error
	// ***************************************************************
	always_comb
	begin
		next_state    = state;
		next_cmd_sr   = cmd_sr;
		next_samp_cnt = samp_cnt;
		next_out_cnt  = out_cnt;
		next_err_cnt  = err_cnt;
		next_rise_dly = {rise_dly[`SCL_SYNC_LAG-2:0], rise_p};
		if (!reconf_s)
			next_state = S_RESET; // [RULE14]
		else
		begin
			unique case (state)
				S_RESET:
					next_state = S_WAIT_STATUS; // [RULE18]
				S_WAIT_STATUS:
					if (status_s && !chain_s)
					begin
						next_state    = S_FETCH;
						next_cmd_sr   = {`SCL_READ_CMD, `SCL_START_ADDR}; // [RULE19]
						next_samp_cnt = '0;
						next_out_cnt  = '0;
					end
				S_FETCH:
				begin
					// shift the command on falling edges; flash latches on rising
					if (fall_p)
						next_cmd_sr = {cmd_sr[`SCL_CMD_BITS-2:0], 1'b0};
					if (strobe && samp_cnt != 6'(`SCL_CMD_BITS))
						next_samp_cnt = samp_cnt + 6'h1;
					if (emit)
						next_out_cnt = out_cnt + CNT_W'(emit_reps);
					if (chain_s)
						next_state = S_WAIT_STATUS; // [RULE13]
					else if (!status_s || (done_s && !done_prev))
					begin
						// a rising done line we still hold low means a wiring fault
						next_state   = S_ERROR; // [RULE17]
						next_err_cnt = '0;
					end
					else if (emit && next_out_cnt >= CNT_W'(IMAGE_BITS))
						next_state = S_DONE; // [RULE3]
				end
				S_DONE:
					next_state = S_DONE;
				S_ERROR:
					if (auto_s)
					begin
						if (err_cnt == 11'(`SCL_RESTART_CYC - 1))
							next_state = S_WAIT_STATUS; // [RULE17]
						else
							next_err_cnt = err_cnt + 11'h1;
					end
				default:
					next_state = S_RESET;
			endcase
		end
	end

	assign flash_command_out = cmd_sr[`SCL_CMD_BITS-1];
	assign load_complete_out = 1'b0;
	assign config_status_out = 1'b0;

	// ***************************************************************
	// registers, all frozen while ce is low
	// ***************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state             <= S_RESET;
			dec               <= D_TYPE;
			cmd_sr            <= '0;
			samp_cnt          <= '0;
			rise_dly          <= '0;
			hdr_seen          <= 1'b0;
			comp              <= 1'b0;
			run_acc           <= '0;
			run_got           <= '0;
			out_cnt           <= '0;
			err_cnt           <= '0;
			done_prev         <= 1'b0;
			run               <= 1'b0;
			flash_select_n    <= 1'b1;
			flash_select_n_oe <= 1'b0;
			flash_command_out_oe <= 1'b0;
			config_clock_oe   <= 1'b0;
			load_complete_oe  <= 1'b1;
			config_status_oe  <= 1'b1;
			chain_enable_out  <= 1'b1;
			cfg_out           <= '0;
		end
		else if (ce)
		begin
			state             <= next_state;
			dec               <= (next_state == S_FETCH) ? next_dec : D_TYPE;
			cmd_sr            <= next_cmd_sr;
			samp_cnt          <= next_samp_cnt;
			rise_dly          <= next_rise_dly;
			hdr_seen          <= (next_state == S_FETCH) && next_hdr_seen;
			comp              <= next_comp;
			run_acc           <= next_run_acc;
			run_got           <= next_run_got;
			out_cnt           <= next_out_cnt;
			err_cnt           <= next_err_cnt;
			done_prev         <= done_s;
			// flash pins driven only while fetching, released otherwise
			run               <= (next_state == S_FETCH); // [RULE1]
			flash_select_n    <= (next_state != S_FETCH); // [RULE19]
			flash_select_n_oe <= (next_state == S_FETCH); // [RULE13]
			flash_command_out_oe <= (next_state == S_FETCH);
			config_clock_oe   <= (next_state == S_FETCH);
			load_complete_oe  <= (next_state != S_DONE); // [RULE16]
			config_status_oe  <= (next_state == S_RESET) || (next_state == S_ERROR);
			chain_enable_out  <= (next_state != S_DONE); // [RULE5]
			cfg_out           <= next_cfg;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	a_isp_release: assert property (@(posedge clk) disable iff (rst) // [RULE13]
		(ce && chain_s) |=> !flash_select_n_oe && !config_clock_oe && !flash_command_out_oe)
		else $error("flash pins driven while chain enable is high");

	a_reset_hold: assert property (@(posedge clk) disable iff (rst) // [RULE14]
		(ce && !reconf_s) |=> state == S_RESET && config_status_oe && !run)
		else $error("activity while reconfigure request is low");

	a_status_release: assert property (@(posedge clk) disable iff (rst) // [RULE18]
		(state == S_WAIT_STATUS) |-> !config_status_oe)
		else $error("status line still held after reset release");

	a_done_release: assert property (@(posedge clk) disable iff (rst) // [RULE16]
		(state == S_FETCH && ce && next_state == S_DONE) |=> !load_complete_oe && !chain_enable_out)
		else $error("load complete not released at image end");

	a_select_fetch: assert property (@(posedge clk) disable iff (rst) // [RULE1]
		!flash_select_n |-> state == S_FETCH && flash_select_n_oe)
		else $error("flash selected outside fetch");

	a_cmd_first: assert property (@(posedge clk) disable iff (rst) // [RULE19]
		$fell(flash_select_n) |-> cmd_sr == {`SCL_READ_CMD, `SCL_START_ADDR} && !config_clock)
		else $error("read command not loaded at select");

	a_error_bound: assert property (@(posedge clk) disable iff (rst) // [RULE17]
		(state == S_ERROR) |-> err_cnt < 11'(`SCL_RESTART_CYC) && config_status_oe)
		else $error("restart wait exceeds its limit");

	a_emit_strobe: assert property (@(posedge clk) disable iff (rst) // [RULE11]
		(ce && cfg_out.valid && $past(ce)) |-> $past(strobe) && $past(state) == S_FETCH)
		else $error("decoded bit without a sampled clock cycle");

endmodule // scl_loader

// ### tb/scl_flash_model.sv
/*
 * Behavioural serial flash on the far side of the loader: takes the read
 * command on config clock rises and streams an image on the falls.
 * Assumes the bench resolves released pins before they reach this model.
 */
`timescale 1ns/100ps

module scl_flash_model
	import scl_pkg::*;
(
	// system
	input  wire logic         clk,
	input  wire logic         rst,
	// flash pins as seen on the board
	input  wire logic         select_n,
	input  wire logic         sclk,
	input  wire logic         cmd_in,
	output logic              data_out,
	// content and observation
	input  wire logic [127:0] image,
	output logic [31:0]       cmd_seen
);
	// *****************************************
	// flash behaviour
	// *****************************************
	logic        prev_sclk;
	int unsigned rises;

	// edges found by comparing with last sampled level; deselected output toggles so no stale bit survives
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prev_sclk <= 1'b0;
			rises     <= 0;
			data_out  <= 1'b0;
			cmd_seen  <= 32'h00000000;
		end
		else
		begin
			prev_sclk <= sclk;
			if (select_n)
			begin
				rises    <= 0;
				data_out <= ~data_out;
			end
			else
			begin
				if (sclk && !prev_sclk)
				begin
					rises <= rises + 1;
					if (rises < 32)
						cmd_seen <= {cmd_seen[30:0], cmd_in}; // msb first
				end
				if (!sclk && prev_sclk && rises >= 32)
					data_out <= image[7'(rises - 32)]; // new bit after fall
			end
		end
	end
endmodule // scl_flash_model

// ### tb/tb.sv
/*
 * Self-checking bench of the serial configuration loader with a flash model.
 * Assumes pull-ups on open-drain lines and a 40 MHz clock.
 */
`timescale 1ns/100ps
`include "scl_defines.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end

module tb
	import scl_pkg::*;
;
	localparam int IMG = 40;
	localparam logic [39:0] PAT = 40'hC3A596F01E;

	// *****************************************
	// signals
	// *****************************************
	logic clk, rst, ce, auto_restart, reconf_n, chain_en, status_low;
	logic [127:0] image;
	logic flash_select_n, flash_select_n_oe, flash_command_out, flash_command_out_oe;
	logic config_clock, config_clock_oe, load_complete_out, load_complete_oe;
	logic config_status_out, config_status_oe, chain_enable_out, flash_data;
	logic [31:0] cmd_seen;
	scl_cfg_t cfg_out;
	scl_pins_t pins;
	int err_total, checks, cyc;
	logic got_q[$];
	time last_rise;
	logic prev_cc;

	// released lines fall to their board pulls
	wire logic sel_w = flash_select_n_oe ? flash_select_n : 1'b1;
	wire logic cc_w = config_clock_oe ? config_clock : 1'b0;
	wire logic cmd_w = flash_command_out_oe ? flash_command_out : 1'b0;
	wire logic status_w = !(config_status_oe | status_low);
	wire logic done_w = !load_complete_oe;
	assign pins = {auto_restart, reconf_n, chain_en, status_w, done_w, flash_data};

	scl_loader #(.IMAGE_BITS(IMG)) scl_loader_i (.clk(clk), .rst(rst), .ce(ce), .pins_in(pins),
		.flash_select_n(flash_select_n), .flash_select_n_oe(flash_select_n_oe),
		.flash_command_out(flash_command_out), .flash_command_out_oe(flash_command_out_oe),
		.config_clock(config_clock), .config_clock_oe(config_clock_oe),
		.load_complete_out(load_complete_out), .load_complete_oe(load_complete_oe),
		.config_status_out(config_status_out), .config_status_oe(config_status_oe),
		.chain_enable_out(chain_enable_out), .cfg_out(cfg_out));

	scl_flash_model scl_flash_model_i (.clk(clk), .rst(rst), .select_n(sel_w), .sclk(cc_w),
		.cmd_in(cmd_w), .data_out(flash_data), .image(image), .cmd_seen(cmd_seen));

	// *****************************************
	// clock, monitors, timeout
	// *****************************************
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// expand decoded runs so plain and compressed images compare alike
	always @(posedge clk)
	begin
		if (cfg_out.valid === 1'b1)
			for (int k = 0; k < cfg_out.reps; k++)
				got_q.push_back(cfg_out.bit_val);
	end

	// rise spacing of the config clock within one frame
	always @(posedge clk)
	begin
		prev_cc <= cc_w;
		if (sel_w || !ce)
			last_rise <= 0;
		else if (cc_w && !prev_cc)
		begin
			if (last_rise != 0)
				`CHK(64'($time - last_rise), 64'd50)
			last_rise <= $time;
		end
	end

	// a hang ends the run as a mismatch
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 15000)
		begin
			err_total++;
			print_verdict();
		end
	end

	// *****************************************
	// helpers
	// *****************************************
	task automatic print_verdict();
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic restart(input logic [127:0] img);
		image    <= img;
		reconf_n <= 1'b0;
		repeat (4) @(posedge clk);
		reconf_n <= 1'b1;
		got_q.delete();
	endtask

	task automatic wait_sel();
		int i;
		i = 0;
		while (sel_w !== 1'b0 && i < 60)
		begin
			@(negedge clk);
			i++;
		end
	endtask

	// bounded wait for the shared done line, then the whole result
	task automatic finish_load(input logic [39:0] exp, input logic exact);
		int i;
		logic [39:0] g;
		i = 0;
		while (load_complete_oe !== 1'b0 && i < 600)
		begin
			@(negedge clk);
			i++;
		end
		@(negedge clk);
		for (int k = 0; k < IMG; k++)
			g[k] = got_q[k];
		`CHK(load_complete_oe, 1'b0)
		`CHK(g, exp)
		`CHK(cmd_seen, {`SCL_READ_CMD, `SCL_START_ADDR})
		`CHK(chain_enable_out, 1'b0)
		`CHK({flash_select_n_oe, config_clock_oe, config_clock}, 3'h0)
		if (exact)
			`CHK(got_q.size(), IMG)
	endtask

	// *****************************************
	// scenarios
	// *****************************************
	task automatic plain_load();
		logic [33:0] snap;
		restart({87'h0, PAT, 1'b0});
		// freeze mid-command: nothing on the link may move while ce is low
		wait_sel();
		repeat (30) @(posedge clk);
		ce <= 1'b0;
		repeat (2) @(negedge clk);
		snap = {config_clock, flash_command_out, cmd_seen};
		repeat (8) @(negedge clk);
		`CHK({config_clock, flash_command_out, cmd_seen}, snap)
		@(posedge clk);
		ce <= 1'b1;
		finish_load(PAT, 1'b1);
	endtask

	// literal one then a run of seven zeros, five times
	task automatic compressed_load();
		logic [127:0] img;
		img = '0;
		img[0] = 1'b1;
		for (int k = 0; k < 5; k++)
			img[1 + 6 * k +: 6] = 6'b011110;
		restart(img);
		finish_load({5{8'h01}}, 1'b0);
	endtask

	// programmer takes the flash mid-fetch, holds reset, then hands back
	task automatic isp_handover();
		logic any;
		restart({87'h0, ~PAT, 1'b0});
		wait_sel();
		repeat (10) @(posedge clk);
		// chain enable alone must abort the fetch before reset is asked for
		chain_en <= 1'b1;
		any = 1'b0;
		repeat (4) @(negedge clk);
		`CHK({config_status_oe, flash_select_n_oe}, 2'h0)
		@(posedge clk);
		reconf_n <= 1'b0;
		for (int k = 0; k < 20; k++)
		begin
			@(negedge clk);
			any = any | flash_select_n_oe | config_clock_oe | flash_command_out_oe;
		end
		`CHK(any, 1'b0)
		`CHK(config_status_oe, 1'b1)
		@(posedge clk);
		chain_en <= 1'b0;
		reconf_n <= 1'b1;
		got_q.delete();
		repeat (6) @(negedge clk);
		`CHK(config_status_oe, 1'b0)
		finish_load(~PAT, 1'b1);
	endtask

	// status pulled low mid-fetch, with and without automatic restart
	task automatic error_restart(input logic auto);
		int n;
		auto_restart <= auto;
		restart({87'h0, PAT, 1'b0});
		wait_sel();
		repeat (20) @(posedge clk);
		status_low <= 1'b1;
		repeat (3) @(posedge clk);
		status_low <= 1'b0;
		@(negedge clk);
		`CHK({config_status_oe, flash_select_n_oe}, 2'h2)
		n = 0;
		while (config_status_oe === 1'b1 && n < 1700)
		begin
			@(negedge clk);
			n++;
		end
		`CHK(n > 1500 && n <= 1600, auto)
		if (auto)
		begin
			got_q.delete();
			finish_load(PAT, 1'b1);
		end
	endtask

	// *****************************************
	// main sequence
	// *****************************************
	initial
	begin
		rst          = 1'b1;
		ce           = 1'b1;
		auto_restart = 1'b0;
		reconf_n     = 1'b1;
		chain_en     = 1'b0; // concurrent load
		status_low   = 1'b0;
		image        = '0;
		err_total    = 0;
		checks       = 0;
		cyc          = 0;
		last_rise    = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		plain_load();
		compressed_load();
		isp_handover();
		error_restart(1'b1);
		error_restart(1'b0);
		print_verdict();
	end
endmodule // tb
